// ==== hdl/csrg_consts.vh ====
`ifndef CSRG_CONSTS_VH
`define CSRG_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSRG_OFS_PBASE 8'hA4
`define CSRG_OFS_MBASE 8'hA6
`define CSRG_OFS_MODE 8'hA8

// ----------------------------------------------------------------
// bits that always read as one, also the reset values
// ----------------------------------------------------------------
`define CSRG_PBASE_ONES 16'h0038
`define CSRG_MBASE_ONES 16'h01F8
`define CSRG_MODE_ONES 16'h8038
`define CSRG_RDATA_IDLE 16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSRG_RDY_MSB 2
`define CSRG_RDY_IGN 2
`define CSRG_RDY_CNT_MSB 1
`define CSRG_SIZE_MSB 14
`define CSRG_SIZE_LSB 8
`define CSRG_SEL_CNT_BIT 7
`define CSRG_MEM_SPACE_BIT 6
`define CSRG_MBASE_MSB 15
`define CSRG_MBASE_LSB 9
`define CSRG_PBASE_MSB 15
`define CSRG_PBASE_LSB 6

// ----------------------------------------------------------------
// address fields of a bus cycle
// ----------------------------------------------------------------
`define CSRG_ADDR_MSB 19
`define CSRG_MID_ADDR_LSB 13
`define CSRG_QUARTER_MSB0 12
`define CSRG_PER_ADDR_LSB 10
`define CSRG_WIN_MSB 9
`define CSRG_WIN_LSB 7
`define CSRG_A1_BIT 1
`define CSRG_A2_BIT 2

// ----------------------------------------------------------------
// decode constants
// ----------------------------------------------------------------
`define CSRG_WIN_NONE 3'h7
`define CSRG_WIN_FIRST_LATCH 3'h5
`define CSRG_WIN_FIRST_HIGH 3'h4
`define CSRG_SIZE_ALL 7'h7F
`define CSRG_SIZE_NONE 7'h00
`define CSRG_SIZE_STEPS 7
`define CSRG_SEL_ONE_MID 4'h1
`define CSRG_SEL_ONE_PER 7'h01
`define CSRG_MID_IDLE 4'hF
`define CSRG_PER_IDLE 7'h7F
`define CSRG_RDY_DEFAULT 3'h0
`define CSRG_RDY_INTERNAL 3'h4

`endif

// ==== hdl/csrg_wait_gen.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// wait-state counter and ready flag for one bus cycle
// ----------------------------------------------------------------
module csrg_wait_gen #(
   parameter CNT_W = 2
) (
   input wire clk_sys_in,
   input wire reset_n_in,
   input wire start_in,
   input wire end_in,
   input wire [CNT_W-1:0] wait_cnt_in,
   input wire ext_ignore_in,
   input wire ext_ready_in,
   output wire ready_out
);

   reg busy_reg; // a cycle is open
   reg [CNT_W-1:0] cnt_reg; // waits still to insert
   reg ready_reg; // cycle may end

   assign ready_out = ready_reg;

   // ----------------------------------------------------------------
   // counter runs beside external ready, so the longer one wins
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         busy_reg <= 1'b0;
         cnt_reg <= {CNT_W{1'b0}};
         ready_reg <= 1'b0;
      end else if (start_in) begin
         // load the count of the range matched
         busy_reg <= 1'b1;
         cnt_reg <= wait_cnt_in;
         ready_reg <= 1'b0;
      end else if (end_in) begin
         busy_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else if (busy_reg) begin
         // count down in parallel, not in series
         if (cnt_reg != {CNT_W{1'b0}}) begin
            cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
         end
         ready_reg <= (cnt_reg == {CNT_W{1'b0}}) &&
            (ext_ignore_in || ext_ready_in);
      end
   end

endmodule

// ==== hdl/csrg_top.v ====
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// - one-hot size bit gives 8K to 512K
// - four equal quarters, select 0 lowest
// - mid base A19-A13 from register bits 15-9
// - mid selects idle until both registers touched
// - seven 128-byte peripheral windows above base
// - peripheral base bits 19-10, 1K aligned
// - space bit picks memory or I/O cycles
// - count bit: selects or latched A1 A2
// - peripheral selects idle until registers touched
// - ready field: waits plus external ready policy
// - internal waits overlap external ready
// - external ready ignored on internal cycles
// - peripheral ready fields split 0-3, 4-6
// - mid base ready field governs mid selects
// - all selects high during reset
// - core and DMA cycles decode alike

`include "csrg_consts.vh"

module csrg_top #(
   parameter ADDR_W = 20,
   parameter REG_AW = 8,
   parameter REG_DW = 16,
   parameter MID_N = 4,
   parameter PER_N = 7
) (
   input wire clk_sys_in,
   input wire reset_n_in,
   input wire [REG_AW-1:0] reg_addr_in,
   input wire [REG_DW-1:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [REG_DW-1:0] reg_rdata_out,
   input wire cycle_start_in,
   input wire cycle_end_in,
   input wire [ADDR_W-1:0] cycle_addr_in,
   input wire cycle_mem_in,
   input wire cycle_internal_in,
   input wire upper_lower_hit_in,
   input wire async_ready_in,
   input wire sync_ready_in,
   output wire [MID_N-1:0] midrange_select_n_out,
   output wire [PER_N-1:0] periph_select_n_out,
   output wire cycle_ready_out
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   reg [REG_DW-1:0] peripheral_base_reg; // base and low ready field
   reg [REG_DW-1:0] midrange_base_reg; // mid base and its ready field
   reg [REG_DW-1:0] periph_mode_midsize_reg; // size, mode, high ready
   reg pbase_seen_reg; // peripheral base touched
   reg mbase_seen_reg; // mid base touched
   reg mode_seen_reg; // mode/size touched
   reg [REG_DW-1:0] rdata_reg; // read answer
   reg [REG_DW-1:0] rdata_next;

   // ----------------------------------------------------------------
   // cycle state
   // ----------------------------------------------------------------
   reg [MID_N-1:0] mid_sel_n_reg; // mid selects, active low
   reg [MID_N-1:0] mid_sel_n_next;
   reg [PER_N-1:0] per_sel_n_reg; // peripheral selects or latched bits
   reg [PER_N-1:0] per_sel_n_next;
   reg [`CSRG_RDY_MSB:0] rdy_field_reg; // ready field of this cycle
   reg [`CSRG_RDY_MSB:0] rdy_field_next;

   // ----------------------------------------------------------------
   // ready pins, two-stage synchronisers
   // ----------------------------------------------------------------
   reg async_meta_reg; // first stage, read only by second
   reg async_sync_reg;
   reg sync_meta_reg; // first stage, read only by second
   reg sync_sync_reg;

   // ----------------------------------------------------------------
   // decode results
   // ----------------------------------------------------------------
   reg [6:0] upper_mask; // address bits above the block size
   reg [1:0] quarter; // which quarter of the mid block
   reg mid_hit; // cycle hits the mid block
   wire [6:0] block_size_field;
   wire [2:0] win; // 128-byte window index
   wire per_hit; // cycle inside the peripheral area
   wire per_is_sel; // window drives a real select
   wire sel_count_opt; // seven selects, no latched bits
   wire mem_space_sel; // peripherals in memory space
   wire ext_ready; // either external ready, synchronised
   wire acc_pbase;
   wire acc_mbase;
   wire acc_mode;
   integer k;

   assign reg_rdata_out = rdata_reg;
   assign midrange_select_n_out = mid_sel_n_reg;
   assign periph_select_n_out = per_sel_n_reg;

   assign block_size_field =
      periph_mode_midsize_reg[`CSRG_SIZE_MSB:`CSRG_SIZE_LSB];
   assign sel_count_opt = periph_mode_midsize_reg[`CSRG_SEL_CNT_BIT];
   assign mem_space_sel = periph_mode_midsize_reg[`CSRG_MEM_SPACE_BIT];
   assign ext_ready = async_sync_reg | sync_sync_reg;

   // any read or write counts as an access
   assign acc_pbase = (reg_wr_in || reg_rd_in) &&
      (reg_addr_in == `CSRG_OFS_PBASE);
   assign acc_mbase = (reg_wr_in || reg_rd_in) &&
      (reg_addr_in == `CSRG_OFS_MBASE);
   assign acc_mode = (reg_wr_in || reg_rd_in) &&
      (reg_addr_in == `CSRG_OFS_MODE);

   // ----------------------------------------------------------------
   // register writes and access tracking
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         // contents are undefined in the part; give them a known value
         peripheral_base_reg <= `CSRG_PBASE_ONES;
         midrange_base_reg <= `CSRG_MBASE_ONES;
         periph_mode_midsize_reg <= `CSRG_MODE_ONES;
         pbase_seen_reg <= 1'b0;
         mbase_seen_reg <= 1'b0;
         mode_seen_reg <= 1'b0;
      end else begin
         if (reg_wr_in && reg_addr_in == `CSRG_OFS_PBASE) begin
            peripheral_base_reg <= reg_wdata_in | `CSRG_PBASE_ONES;
         end
         if (reg_wr_in && reg_addr_in == `CSRG_OFS_MBASE) begin
            midrange_base_reg <= reg_wdata_in | `CSRG_MBASE_ONES;
         end
         if (reg_wr_in && reg_addr_in == `CSRG_OFS_MODE) begin
            periph_mode_midsize_reg <= reg_wdata_in | `CSRG_MODE_ONES;
         end
         // flags only ever set, so a late access is never lost
         if (acc_pbase) begin
            pbase_seen_reg <= 1'b1;
         end
         if (acc_mbase) begin
            mbase_seen_reg <= 1'b1;
         end
         if (acc_mode) begin
            mode_seen_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // read data, valid in the cycle after the strobe only
   // ----------------------------------------------------------------
   always @* begin
      rdata_next = `CSRG_RDATA_IDLE;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `CSRG_OFS_PBASE: begin
               rdata_next = peripheral_base_reg;
            end
            `CSRG_OFS_MBASE: begin
               rdata_next = midrange_base_reg;
            end
            `CSRG_OFS_MODE: begin
               rdata_next = periph_mode_midsize_reg;
            end
            default: begin
               // unmapped offsets read as zero
               rdata_next = `CSRG_RDATA_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         rdata_reg <= `CSRG_RDATA_IDLE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // external ready synchronisers
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         async_meta_reg <= 1'b0;
         async_sync_reg <= 1'b0;
         sync_meta_reg <= 1'b0;
         sync_sync_reg <= 1'b0;
      end else begin
         async_meta_reg <= async_ready_in;
         async_sync_reg <= async_meta_reg;
         sync_meta_reg <= sync_ready_in;
         sync_sync_reg <= sync_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // mid-range decode
   // ----------------------------------------------------------------
   // a bad size pattern picks the highest set bit; result undefined
   always @* begin
      upper_mask = `CSRG_SIZE_ALL;
      quarter = 2'b00;
      for (k = 0; k < `CSRG_SIZE_STEPS; k = k + 1) begin
         if (block_size_field[k]) begin
            // block is 8K shifted up by k, top address bits compared
            upper_mask = `CSRG_SIZE_ALL << k;
            // two bits just below the compared ones pick the quarter
            quarter = cycle_addr_in[`CSRG_QUARTER_MSB0 + k -: 2];
         end
      end
      // base bits A12-A0 are implied zero by the field width
      mid_hit = mbase_seen_reg && mode_seen_reg &&
         cycle_mem_in && !cycle_internal_in &&
         !upper_lower_hit_in &&
         (block_size_field != `CSRG_SIZE_NONE) &&
         ((cycle_addr_in[`CSRG_ADDR_MSB:`CSRG_MID_ADDR_LSB] &
         upper_mask) ==
         (midrange_base_reg[`CSRG_MBASE_MSB:`CSRG_MBASE_LSB] &
         upper_mask));
   end

   // ----------------------------------------------------------------
   // peripheral decode
   // ----------------------------------------------------------------
   assign win = cycle_addr_in[`CSRG_WIN_MSB:`CSRG_WIN_LSB];

   // the base compare covers A19-A10, so I/O needs zero top bits
   assign per_hit = pbase_seen_reg && mode_seen_reg &&
      !cycle_internal_in &&
      (cycle_mem_in == mem_space_sel) &&
      (cycle_addr_in[`CSRG_ADDR_MSB:`CSRG_PER_ADDR_LSB] ==
      peripheral_base_reg[`CSRG_PBASE_MSB:`CSRG_PBASE_LSB]) &&
      (win != `CSRG_WIN_NONE);

   // upper two windows are not selects while bits are latched
   assign per_is_sel = per_hit &&
      (sel_count_opt || (win < `CSRG_WIN_FIRST_LATCH));

   // ----------------------------------------------------------------
   // next select and ready field
   // ----------------------------------------------------------------
   always @* begin
      mid_sel_n_next = mid_sel_n_reg;
      per_sel_n_next = per_sel_n_reg;
      rdy_field_next = rdy_field_reg;
      if (cycle_start_in) begin
         // core and DMA cycles look the same here
         mid_sel_n_next = `CSRG_MID_IDLE;
         per_sel_n_next = `CSRG_PER_IDLE;
         if (mid_hit) begin
            mid_sel_n_next = ~(`CSRG_SEL_ONE_MID << quarter);
         end
         if (!sel_count_opt) begin
            // latched address bits replace the top two selects
            per_sel_n_next[5] = cycle_addr_in[`CSRG_A1_BIT];
            per_sel_n_next[6] = cycle_addr_in[`CSRG_A2_BIT];
         end
         if (per_is_sel) begin
            per_sel_n_next = per_sel_n_next &
               ~(`CSRG_SEL_ONE_PER << win);
         end
         // capture the matched range's ready field
         if (cycle_internal_in) begin
            rdy_field_next = `CSRG_RDY_INTERNAL;
         end else if (mid_hit) begin
            rdy_field_next = midrange_base_reg[`CSRG_RDY_MSB:0];
         end else if (per_hit && win < `CSRG_WIN_FIRST_HIGH) begin
            rdy_field_next =
               peripheral_base_reg[`CSRG_RDY_MSB:0];
         end else if (per_hit) begin
            rdy_field_next =
               periph_mode_midsize_reg[`CSRG_RDY_MSB:0];
         end else begin
            // no range matched: no waits, external ready decides
            rdy_field_next = `CSRG_RDY_DEFAULT;
         end
      end else if (cycle_end_in) begin
         // selects drop when the bus cycle closes
         mid_sel_n_next = `CSRG_MID_IDLE;
         per_sel_n_next = `CSRG_PER_IDLE;
         if (!sel_count_opt) begin
            per_sel_n_next[6:5] = per_sel_n_reg[6:5];
         end
      end
   end

   // ----------------------------------------------------------------
   // select and ready field flops
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         mid_sel_n_reg <= `CSRG_MID_IDLE;
         per_sel_n_reg <= `CSRG_PER_IDLE;
         rdy_field_reg <= `CSRG_RDY_DEFAULT;
      end else begin
         mid_sel_n_reg <= mid_sel_n_next;
         per_sel_n_reg <= per_sel_n_next;
         rdy_field_reg <= rdy_field_next;
      end
   end

   // ----------------------------------------------------------------
   // wait-state generator
   // ----------------------------------------------------------------
   // the start cycle uses the field being captured, later cycles the
   // held copy, so a register write mid-cycle cannot change the waits
   csrg_wait_gen #(
      .CNT_W(2)
   ) u_wait (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .start_in(cycle_start_in),
      .end_in(cycle_end_in),
      .wait_cnt_in(rdy_field_next[`CSRG_RDY_CNT_MSB:0]),
      .ext_ignore_in(rdy_field_reg[`CSRG_RDY_IGN]),
      .ext_ready_in(ext_ready),
      .ready_out(cycle_ready_out)
   );

endmodule

// ==== verification/csrg_top_assertions.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the select and ready block
// ----------------------------------------------------------------
module csrg_top_assertions #(
   parameter REG_AW = 8,
   parameter MID_N = 4,
   parameter PER_N = 7
) (
   input wire clk_sys_in,
   input wire reset_n_in,
   input wire [REG_AW-1:0] reg_addr_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [15:0] reg_rdata_out,
   input wire cycle_start_in,
   input wire cycle_end_in,
   input wire cycle_mem_in,
   input wire cycle_internal_in,
   input wire upper_lower_hit_in,
   input wire [MID_N-1:0] midrange_select_n_out,
   input wire [PER_N-1:0] periph_select_n_out,
   input wire cycle_ready_out
);
   reg [2:0] seen_reg; // pbase, mbase, mode touched since reset
   // access flags, only ever set: mirrors the unlock of the selects
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         seen_reg <= 3'h0;
      end else if (reg_wr_in || reg_rd_in) begin
         seen_reg <= seen_reg | {reg_addr_in == 8'hA8,
            reg_addr_in == 8'hA6, reg_addr_in == 8'hA4};
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   property p_reset_idle;
      disable iff (1'b0) !reset_n_in |=> &midrange_select_n_out &&
         &periph_select_n_out && !cycle_ready_out;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("select or ready active after reset edge");
   property p_one_mid;
      $onehot0(~midrange_select_n_out);
   endproperty
   a_one_mid: assert property (p_one_mid)
      else $error("more than one mid select low");
   property p_sel_hold;
      !cycle_start_in && !cycle_end_in |=>
         $stable(midrange_select_n_out) && $stable(periph_select_n_out);
   endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("select moved inside a bus cycle");
   property p_end_idle;
      cycle_end_in && !cycle_start_in |=> &midrange_select_n_out &&
         &periph_select_n_out[4:0] && !cycle_ready_out;
   endproperty
   a_end_idle: assert property (p_end_idle)
      else $error("select or ready kept after cycle end");
   property p_internal;
      cycle_start_in && cycle_internal_in ##1 !cycle_start_in &&
         !cycle_end_in |=> cycle_ready_out && &midrange_select_n_out &&
         &periph_select_n_out[4:0];
   endproperty
   a_internal: assert property (p_internal)
      else $error("internal cycle not ready at once or selected");
   property p_mid_space;
      cycle_start_in && (!cycle_mem_in || upper_lower_hit_in) |=>
         &midrange_select_n_out;
   endproperty
   a_mid_space: assert property (p_mid_space)
      else $error("mid select on io or excluded cycle");
   property p_mid_locked;
      !(seen_reg[1] && seen_reg[2]) |-> &midrange_select_n_out;
   endproperty
   a_mid_locked: assert property (p_mid_locked)
      else $error("mid select before both registers touched");
   property p_per_locked;
      !(seen_reg[0] && seen_reg[2]) |-> &periph_select_n_out[4:0];
   endproperty
   a_per_locked: assert property (p_per_locked)
      else $error("periph select before both registers touched");
   property p_rd_idle;
      !reg_rd_in |=> reg_rdata_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its cycle");
   property p_ready_late;
      $rose(cycle_ready_out) |-> !$past(cycle_start_in);
   endproperty
   a_ready_late: assert property (p_ready_late)
      else $error("ready in the cycle after start");
endmodule
bind csrg_top csrg_top_assertions #(.REG_AW(REG_AW), .MID_N(MID_N),
   .PER_N(PER_N)) u_csrg_top_assertions (.clk_sys_in, .reset_n_in,
   .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cycle_start_in,
   .cycle_end_in, .cycle_mem_in, .cycle_internal_in, .upper_lower_hit_in,
   .midrange_select_n_out, .periph_select_n_out, .cycle_ready_out);

// ==== verification/csrg_dev_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-side memories and peripherals: ready after a set delay
// ----------------------------------------------------------------
module csrg_dev_model (
   input wire clk_sys_in,
   input wire open_in,
   input wire [3:0] delay_in,
   input wire use_sync_in,
   output reg async_ready_out,
   output reg sync_ready_out
);
   reg [3:0] cnt_reg; // cycles since the bus cycle opened
   // prompt or slow answer on one of the two ready pins
   always @(posedge clk_sys_in) begin
      if (!open_in) begin
         cnt_reg <= 4'h0;
         async_ready_out <= 1'b0;
         sync_ready_out <= 1'b0;
      end else begin
         // saturate so a long wait never wraps back to not-ready
         if (cnt_reg != 4'hF) begin
            cnt_reg <= cnt_reg + 4'h1;
         end
         async_ready_out <= !use_sync_in && cnt_reg >= delay_in;
         sync_ready_out <= use_sync_in && cnt_reg >= delay_in;
      end
   end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`include "csrg_consts.vh"
module tb;
   reg clk_sys_in = 1'b0;
   reg reset_n_in = 1'b0;
   reg [7:0] reg_addr_in = 8'h00;
   reg [15:0] reg_wdata_in = 16'h0000;
   reg reg_wr_in = 1'b0;
   reg reg_rd_in = 1'b0;
   reg cycle_start_in = 1'b0;
   reg cycle_end_in = 1'b0;
   reg [19:0] cycle_addr_in = 20'h00000;
   reg cycle_mem_in = 1'b1;
   reg cycle_internal_in = 1'b0;
   reg upper_lower_hit_in = 1'b0;
   reg open_reg = 1'b0; // bus cycle open, seen by far side
   reg [3:0] delay_reg = 4'h0;
   reg use_sync_reg = 1'b0;
   wire async_ready_in;
   wire sync_ready_in;
   wire [15:0] reg_rdata_out;
   wire [3:0] midrange_select_n_out;
   wire [6:0] periph_select_n_out;
   wire cycle_ready_out;
   integer num_errors = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer lat, k, n, w;
   reg [3:0] ms;
   reg [6:0] ps;
   reg [15:0] rv, wv;
   reg [19:0] a, bs;
   reg [9:0] pb;
   reg [6:0] b7;
   reg [2:0] r, r2;
   csrg_top u_csrg_top (.clk_sys_in, .reset_n_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cycle_start_in,
      .cycle_end_in, .cycle_addr_in, .cycle_mem_in, .cycle_internal_in,
      .upper_lower_hit_in, .async_ready_in, .sync_ready_in,
      .midrange_select_n_out, .periph_select_n_out, .cycle_ready_out);
   csrg_dev_model u_csrg_dev_model (.clk_sys_in, .open_in(open_reg),
      .delay_in(delay_reg), .use_sync_in(use_sync_reg),
      .async_ready_out(async_ready_in), .sync_ready_out(sync_ready_in));
   always #5 clk_sys_in = ~clk_sys_in;
   // hang guard, far above the well under a thousand cycles needed
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors = num_errors + 1;
         close_out;
      end
   end
   task chk(input [63:0] what, input [19:0] seen, input [19:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] ad, input [15:0] d);
      begin
         reg_addr_in <= ad;
         reg_wdata_in <= d;
         reg_wr_in <= 1'b1;
         @(posedge clk_sys_in);
         reg_wr_in <= 1'b0;
         @(posedge clk_sys_in);
      end
   endtask
   task rd(input [7:0] ad);
      begin
         reg_addr_in <= ad;
         reg_rd_in <= 1'b1;
         @(posedge clk_sys_in);
         reg_rd_in <= 1'b0;
         #1 rv = reg_rdata_out;
         @(posedge clk_sys_in);
      end
   endtask
   // one bus cycle: selects seen in the cycle after start, ready counted
   task run(input [19:0] ad, input m, input i, input u);
      begin
         cycle_addr_in <= ad;
         cycle_mem_in <= m;
         cycle_internal_in <= i;
         upper_lower_hit_in <= u;
         cycle_start_in <= 1'b1;
         open_reg <= 1'b1;
         @(posedge clk_sys_in);
         cycle_start_in <= 1'b0;
         #1 ms = midrange_select_n_out;
         ps = periph_select_n_out;
         lat = 99;
         for (n = 1; n < 40 && lat == 99; n = n + 1) begin
            if (cycle_ready_out === 1'b1) begin
               lat = n;
            end else begin
               @(posedge clk_sys_in);
               #1;
            end
         end
         @(posedge clk_sys_in);
         cycle_end_in <= 1'b1;
         open_reg <= 1'b0;
         @(posedge clk_sys_in);
         cycle_end_in <= 1'b0;
      end
   endtask
   function [3:0] mid_exp(input [19:0] ad, input [19:0] b, input integer s);
      reg [20:0] off;
      begin
         off = {1'b0, ad} - {1'b0, b};
         mid_exp = 4'hF;
         if (ad >= b && off < (21'h1 << (13 + s))) begin
            mid_exp = ~(4'h1 << (off >> (11 + s)));
         end
      end
   endfunction
   function [6:0] per_exp(input [19:0] ad, input [9:0] p, input ex,
      input ok);
      begin
         per_exp = 7'h7F;
         if (ok && ad[19:10] == p && ad[9:7] != 3'h7 &&
            (ex || ad[9:7] < 3'h5)) begin
            per_exp[ad[9:7]] = 1'b0;
         end
         if (!ex) begin
            per_exp[6:5] = {ad[2], ad[1]};
         end
      end
   endfunction
   task close_out;
      begin
         if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   initial begin
      k = $urandom(32'h80B926DE);
      repeat (16) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      @(posedge clk_sys_in);
      // only the mode register touched: mid selects and peripheral selects 0-4 must stay idle
      wr(`CSRG_OFS_MODE, 16'h84BC);
      run(20'h00000, 1'b1, 1'b0, 1'b0);
      chk("mlock", ms, 4'hF);
      chk("plock", ps[4:0], 5'h1F);
      rd(8'hAA);
      chk("unmap", rv, 16'h0000);
      for (k = 0; k < 3; k = k + 1) begin
         wv = $urandom;
         wr(8'hA4 + 8'(2 * k), wv);
         rd(8'hA4 + 8'(2 * k));
         chk("reg", rv, wv | (k == 0 ? `CSRG_PBASE_ONES : k == 1 ?
            `CSRG_MBASE_ONES : `CSRG_MODE_ONES));
      end
      // every block size, random aligned base, ext ready ignored
      for (k = 0; k < 7; k = k + 1) begin
         b7 = $urandom;
         b7 = (k == 6) ? 7'h00 : b7 & ~((7'h1 << k) - 7'h1);
         r = $urandom;
         r[2] = 1'b1;
         wr(`CSRG_OFS_MBASE, {b7, 6'h3F, r});
         wr(`CSRG_OFS_MODE, {1'b1, 7'h1 << k, 8'hBC});
         bs = {b7, 13'h0000};
         a = bs + (20'($urandom) & ((20'h2000 << k) - 20'h1));
         run(a, 1'b1, 1'b0, 1'b0);
         chk("mid", ms, mid_exp(a, bs, k));
         chk("lat", lat, 2 + r[1:0]);
         run(bs + (20'h2000 << k) - 20'h1, 1'b1, 1'b0, 1'b0);
         chk("mtop", ms, 4'h7);
         run(bs + (20'h2000 << k), 1'b1, 1'b0, 1'b0);
         chk("mout", ms, mid_exp(bs + (20'h2000 << k), bs, k));
         run(a, 1'b1, 1'b0, 1'b1);
         chk("mexcl", ms, 4'hF);
         run(a, 1'b0, 1'b0, 1'b0);
         chk("mio", ms, 4'hF);
      end
      // waits overlap slow external ready, async then sync pin
      wr(`CSRG_OFS_MODE, 16'h81BC);
      for (k = 0; k < 3; k = k + 1) begin
         wr(`CSRG_OFS_MBASE, k == 1 ? 16'hFFF8 : 16'hFFFB);
         delay_reg <= (k == 0) ? 4'h2 : 4'h6;
         use_sync_reg <= k[0];
         run(20'hFE000, 1'b1, 1'b0, 1'b0);
         w = (k == 0) ? 5 : 9;
         chk("extrdy", lat >= w && lat <= w + 1, 1'b1);
      end
      delay_reg <= 4'hF;
      run(20'hFE000, 1'b1, 1'b1, 1'b0);
      chk("intl", {ms, 16'(lat)}, {4'hF, 16'h0002});
      delay_reg <= 4'h0;
      // all modes: space, select count, every window, split ready fields
      for (k = 0; k < 4; k = k + 1) begin
         pb = $urandom;
         pb[9] = 1'b0;
         if (!k[1]) pb[9:6] = 4'h0;
         r = $urandom;
         r2 = $urandom;
         wr(`CSRG_OFS_PBASE, {pb, 4'hF, r[1:0]});
         wr(`CSRG_OFS_MODE, {8'h81, k[0], k[1], 4'hF, r2[1:0]});
         for (w = 0; w < 7; w = w + 1) begin
            a = {pb, w[2:0], 7'($urandom)};
            run(a, k[1], 1'b0, 1'b0);
            chk("per", ps, per_exp(a, pb, k[0], 1'b1));
            chk("pmid", ms, 4'hF);
            if (k[0] || w < 5) begin
               chk("plat", lat, 2 + (w < 4 ? r[1:0] : r2[1:0]));
            end
         end
         run(a, !k[1], 1'b0, 1'b0);
         chk("pspc", ps, per_exp(a, pb, k[0], 1'b0));
      end
      // reset in mid cycle drops the selects and locks them again
      cycle_addr_in <= 20'hFE000;
      cycle_mem_in <= 1'b1;
      cycle_start_in <= 1'b1;
      @(posedge clk_sys_in);
      cycle_start_in <= 1'b0;
      reset_n_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 chk("rst", {midrange_select_n_out, periph_select_n_out},
         11'h7FF);
      @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      @(posedge clk_sys_in);
      run(20'hFE000, 1'b1, 1'b0, 1'b0);
      chk("relock", ms, 4'hF);
      close_out;
   end
endmodule
